// file: rtl/cmmc_top.sv
// mailbox mode decode, receive store selection and operating mode control
// assumes the register port strobes are one cycle long and never overlap
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "cmmc_defs.svh"
module cmmc_top #(
	parameter int NUM_MB = `CMMC_NUM_MB,
	parameter int PSC_W  = `CMMC_PSC_W
) (
	input  wire logic                    CORE_CLK,
	input  wire logic                    RESET,
	input  wire logic                    CE,
	input  wire logic [`CMMC_ADDR_W-1:0] ADDR,
	input  wire logic [`CMMC_DATA_W-1:0] WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [`CMMC_DATA_W-1:0] RDATA,
	input  wire cmmc_pkg::cmmc_rxreq_s   RX_REQ,
	input  wire logic [NUM_MB-1:0]       ABORT_BUSY,
	output logic                         RX_STORE,
	output logic      [4:0]              RX_MB,
	output logic                         RX_ACK,
	output logic      [NUM_MB-1:0]       TX_ENABLE,
	output logic      [NUM_MB-1:0]       TX_SINGLE,
	output logic                         COMM_RUN,
	output logic                         TQ_TICK,
	output logic                         BUS_TRANSMIT_PIN
);
	logic [`CMMC_MC_W-1:0]   mctl_reg [NUM_MB];
	logic [`CMMC_MC_W-1:0]   mctl_next [NUM_MB];
	logic [1:0]              mode_cmd_reg, mode_cmd_next;
	logic                    sleep_cmd_reg, sleep_cmd_next;
	logic                    mbm_reg, mbm_next;
	logic                    selftest_reg, selftest_next;
	logic [`CMMC_DATA_W-1:0] timing_reg, timing_next;
	logic [`CMMC_DATA_W-1:0] mier_reg, mier_next;
	logic [`CMMC_DATA_W-1:0] mask_dis_reg, mask_dis_next;
	logic [`CMMC_DATA_W-1:0] mask_reg [8];
	logic [`CMMC_DATA_W-1:0] mask_next [8];
	cmmc_pkg::cmmc_mode_e    mode_reg, mode_next;
	logic                    sleep_reg, sleep_next;
	cmmc_pkg::cmmc_fsm_e     st_reg, st_next;
	logic [3:0]              settle_reg, settle_next;
	logic [`CMMC_DATA_W-1:0] rdata_reg, rdata_next;
	logic                    store_reg, store_next;
	logic [4:0]              mb_reg, mb_next;
	logic                    ack_reg, ack_next;
	logic                    wr_mctl, wr_mask;
	logic [4:0]              sel;
	logic                    hw_rst;

	assign wr_mctl = WR && (ADDR[7:5] == `CMMC_A_MCTL_SEL_HI);
	assign wr_mask = WR && (ADDR[7:3] == `CMMC_A_MASK_SEL_HI);
	assign sel     = ADDR[4:0];
	// mailbox settings are cleared while the channel sits in reset mode
	assign hw_rst  = (mode_reg == cmmc_pkg::CMMC_RESET);

	function automatic cmmc_pkg::cmmc_mbmode_e decode(input logic [`CMMC_MC_W-1:0] m);
		logic t, r, o;
		t = m[`CMMC_MC_TX];
		r = m[`CMMC_MC_RX];
		o = m[`CMMC_MC_ONE];
		if (t && r)
			decode = cmmc_pkg::CMMC_MB_BAD;
		else if (t)
			decode = o ? cmmc_pkg::CMMC_MB_TX1 : cmmc_pkg::CMMC_MB_TX;
		else if (r)
			decode = o ? cmmc_pkg::CMMC_MB_RX1 : cmmc_pkg::CMMC_MB_RX;
		else
			decode = o ? cmmc_pkg::CMMC_MB_ABT1 : cmmc_pkg::CMMC_MB_OFF;
	endfunction

	// register writes
	always_comb
	begin
		mode_cmd_next  = mode_cmd_reg;
		sleep_cmd_next = sleep_cmd_reg;
		mbm_next       = mbm_reg;
		selftest_next  = selftest_reg;
		timing_next    = timing_reg;
		mier_next      = mier_reg;
		mask_dis_next  = mask_dis_reg;
		for (int i = 0; i < 8; i++)
			mask_next[i] = mask_reg[i];
		for (int i = 0; i < NUM_MB; i++)
			mctl_next[i] = mctl_reg[i];
		if (WR && ADDR == `CMMC_A_CTRL && st_reg != cmmc_pkg::CMMC_ST_SWITCH)
		begin
			mode_cmd_next  = WDATA[`CMMC_CTRL_MODE_LO +: 2];
			sleep_cmd_next = WDATA[`CMMC_CTRL_SLEEP];
			mbm_next       = WDATA[`CMMC_CTRL_MBM];
			selftest_next  = WDATA[`CMMC_CTRL_SELFTEST];
		end
		if (WR && ADDR == `CMMC_A_TIMING && mode_reg != cmmc_pkg::CMMC_OPERATE)
			timing_next = WDATA;
		if (WR && ADDR == `CMMC_A_MIER)
			mier_next = WDATA;
		if (WR && ADDR == `CMMC_A_MASK_DIS)
			mask_dis_next = WDATA;
		if (wr_mask)
			mask_next[sel[2:0]] = WDATA;
		if (wr_mctl && int'(sel) < NUM_MB)
			mctl_next[sel] = WDATA[`CMMC_MC_W-1:0];
		if (hw_rst)
		begin
			// mailbox settings are lost in reset mode; timing, interrupt
			// enable and masks persist and also survive halt mode
			for (int i = 0; i < NUM_MB; i++)
				mctl_next[i] = '0;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			mode_cmd_reg  <= `CMMC_MODE_CMD_RST;
			sleep_cmd_reg <= 1'b0;
			mbm_reg       <= 1'b0;
			selftest_reg  <= 1'b0;
			timing_reg    <= `CMMC_TIMING_RST;
			mier_reg      <= '0;
			mask_dis_reg  <= '0;
			for (int i = 0; i < 8; i++)
				mask_reg[i] <= '0;
			for (int i = 0; i < NUM_MB; i++)
				mctl_reg[i] <= '0;
		end
		else if (CE)
		begin
			mode_cmd_reg  <= mode_cmd_next;
			sleep_cmd_reg <= sleep_cmd_next;
			mbm_reg       <= mbm_next;
			selftest_reg  <= selftest_next;
			timing_reg    <= timing_next;
			mier_reg      <= mier_next;
			mask_dis_reg  <= mask_dis_next;
			for (int i = 0; i < 8; i++)
				mask_reg[i] <= mask_next[i];
			for (int i = 0; i < NUM_MB; i++)
				mctl_reg[i] <= mctl_next[i];
		end
	end

	// mode switching: status follows command only after settling
	always_comb
	begin
		st_next     = st_reg;
		settle_next = settle_reg;
		mode_next   = mode_reg;
		sleep_next  = sleep_reg;
		case (st_reg)
			cmmc_pkg::CMMC_ST_IDLE:
				if (mode_cmd_reg != mode_reg || sleep_cmd_reg != sleep_reg)
				begin
					st_next     = cmmc_pkg::CMMC_ST_SWITCH;
					settle_next = `CMMC_MODE_SETTLE;
				end
			cmmc_pkg::CMMC_ST_SWITCH:
				if (settle_reg == 4'h0)
				begin
					mode_next  = cmmc_pkg::cmmc_mode_e'(mode_cmd_reg);
					sleep_next = sleep_cmd_reg;
					st_next    = sleep_cmd_reg ? cmmc_pkg::CMMC_ST_SLEEP
						: cmmc_pkg::CMMC_ST_IDLE;
				end
				else
					settle_next = settle_reg - 4'h1;
			cmmc_pkg::CMMC_ST_SLEEP:
				if (!sleep_cmd_reg)
				begin
					st_next     = cmmc_pkg::CMMC_ST_SWITCH;
					settle_next = `CMMC_MODE_SETTLE;
				end
			default:
				st_next = cmmc_pkg::CMMC_ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			st_reg     <= cmmc_pkg::CMMC_ST_IDLE;
			settle_reg <= 4'h0;
			mode_reg   <= cmmc_pkg::CMMC_RESET;
			sleep_reg  <= 1'b0;
		end
		else if (CE)
		begin
			st_reg     <= st_next;
			settle_reg <= settle_next;
			mode_reg   <= mode_next;
			sleep_reg  <= sleep_next;
		end
	end

	// receive store selection, read data
	always_comb
	begin
		cmmc_pkg::cmmc_mbmode_e m;
		m          = cmmc_pkg::CMMC_MB_OFF;
		store_next = 1'b0;
		mb_next    = mb_reg;
		ack_next   = 1'b0;
		rdata_next = '0;
		if (RX_REQ.valid && COMM_RUN && !mbm_reg && !(RX_REQ.own && !selftest_reg))
		begin
			ack_next = RX_REQ.own;
			for (int i = NUM_MB - 1; i >= 0; i--)
			begin
				m = decode(mctl_reg[i]);
				if (RX_REQ.accept[i] && (m == cmmc_pkg::CMMC_MB_RX || m == cmmc_pkg::CMMC_MB_RX1))
				begin
					store_next = 1'b1;
					mb_next    = 5'(i);
				end
			end
		end
		if (RD)
		begin
			if (ADDR == `CMMC_A_CTRL)
				rdata_next = {27'h0, selftest_reg, mbm_reg, sleep_cmd_reg, mode_cmd_reg};
			else if (ADDR == `CMMC_A_STATUS)
				rdata_next = {28'h0, st_reg != cmmc_pkg::CMMC_ST_IDLE &&
					st_reg != cmmc_pkg::CMMC_ST_SLEEP, sleep_reg, mode_reg};
			else if (ADDR == `CMMC_A_TIMING)
				rdata_next = timing_reg;
			else if (ADDR == `CMMC_A_MIER)
				rdata_next = mier_reg;
			else if (ADDR == `CMMC_A_MASK_DIS)
				rdata_next = mask_dis_reg;
			else if (ADDR[7:3] == `CMMC_A_MASK_SEL_HI)
				rdata_next = mask_reg[sel[2:0]];
			else if (ADDR[7:5] == `CMMC_A_MCTL_SEL_HI && int'(sel) < NUM_MB)
				rdata_next = {24'h0, mctl_reg[sel]};
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			store_reg <= 1'b0;
			mb_reg    <= 5'h0;
			ack_reg   <= 1'b0;
			rdata_reg <= '0;
		end
		else if (CE)
		begin
			store_reg <= store_next;
			mb_reg    <= mb_next;
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// transmit eligibility; each mailbox waits for its own pending abort to finish
	always_comb
	begin
		cmmc_pkg::cmmc_mbmode_e m;
		m         = cmmc_pkg::CMMC_MB_OFF;
		TX_ENABLE = '0;
		TX_SINGLE = '0;
		for (int i = 0; i < NUM_MB; i++)
		begin
			m = decode(mctl_reg[i]);
			TX_ENABLE[i] = COMM_RUN && !mbm_reg && !ABORT_BUSY[i] &&
				(m == cmmc_pkg::CMMC_MB_TX || m == cmmc_pkg::CMMC_MB_TX1);
			TX_SINGLE[i] = (m == cmmc_pkg::CMMC_MB_TX1);
		end
	end

	cmmc_tq_div #(
		.PSC_W(PSC_W)
	) u_div (
		.CORE_CLK(CORE_CLK),
		.RESET   (RESET),
		.CE      (CE),
		.run     (mode_reg != cmmc_pkg::CMMC_RESET),
		.prescale(timing_reg[PSC_W-1:0]),
		.tq_tick (TQ_TICK)
	);

	// halt and reset modes both stop traffic; halt keeps settings
	assign COMM_RUN         = (mode_reg == cmmc_pkg::CMMC_OPERATE) && !sleep_reg;
	assign BUS_TRANSMIT_PIN = 1'b1;
	assign RDATA            = rdata_reg;
	assign RX_STORE         = store_reg;
	assign RX_MB            = mb_reg;
	assign RX_ACK           = ack_reg;
endmodule

// file: rtl/cmmc_tq_div.sv
// quantum clock enable: divides the system clock by prescaler plus one
// assumes prescaler is stable while the channel is out of reset mode
`timescale 1ns/1ps
`include "cmmc_defs.svh"
module cmmc_tq_div #(
	parameter int PSC_W = `CMMC_PSC_W
) (
	input  wire logic             CORE_CLK,
	input  wire logic             RESET,
	input  wire logic             CE,
	input  wire logic             run,
	input  wire logic [PSC_W-1:0] prescale,
	output logic                  tq_tick
);
	logic [PSC_W-1:0] cnt_reg;
	logic [PSC_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;

	always_comb
	begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (!run)
			cnt_next = '0;
		else if (cnt_reg >= prescale)
		begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end
		else
			cnt_next = cnt_reg + 1'b1;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else if (CE)
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tq_tick = tick_reg;
endmodule

// file: shared/cmmc_defs.svh
// constants for the mailbox mode and operating mode configuration block
// assumes one clock domain and a plain register port with one-cycle strobes
`ifndef CMMC_DEFS_SVH
`define CMMC_DEFS_SVH

`define CMMC_NUM_MB          32
`define CMMC_ADDR_W          8
`define CMMC_DATA_W          32
// register addresses
`define CMMC_A_CTRL          8'h00
`define CMMC_A_STATUS        8'h01
`define CMMC_A_TIMING        8'h02
`define CMMC_A_MIER          8'h03
`define CMMC_A_MASK_DIS      8'h04
`define CMMC_A_MASK0         8'h08
`define CMMC_A_MCTL0         8'h20
`define CMMC_A_MASK_SEL_HI   5'h01
`define CMMC_A_MCTL_SEL_HI   3'h1
// control register fields
`define CMMC_CTRL_MODE_LO    0
`define CMMC_CTRL_SLEEP      2
`define CMMC_CTRL_MBM        3
`define CMMC_CTRL_SELFTEST   4
// mailbox control fields
`define CMMC_MC_TX           7
`define CMMC_MC_RX           6
`define CMMC_MC_ONE          5
`define CMMC_MC_W            8
// reset values and prescaler width
`define CMMC_TIMING_RST      32'h0000_0000
`define CMMC_MODE_CMD_RST    2'h1
`define CMMC_PSC_W           10
// settle countdown start; the switch state lasts this many cycles plus one
`define CMMC_MODE_SETTLE     4'h3

`endif

// file: shared/cmmc_pkg.sv
// types shared by the mailbox mode configuration block
// assumes cmmc_defs.svh is the source of every number
package cmmc_pkg;

	typedef enum logic [1:0] {
		CMMC_OPERATE = 2'h0,
		CMMC_RESET   = 2'h1,
		CMMC_HALT    = 2'h2
	} cmmc_mode_e;

	typedef enum logic [2:0] {
		CMMC_MB_OFF   = 3'h0,
		CMMC_MB_RX    = 3'h1,
		CMMC_MB_RX1   = 3'h2,
		CMMC_MB_TX    = 3'h3,
		CMMC_MB_TX1   = 3'h4,
		CMMC_MB_ABT1  = 3'h5,
		CMMC_MB_BAD   = 3'h6
	} cmmc_mbmode_e;

	typedef enum logic [2:0] {
		CMMC_ST_IDLE   = 3'b001,
		CMMC_ST_SWITCH = 3'b010,
		CMMC_ST_SLEEP  = 3'b100
	} cmmc_fsm_e;

	typedef struct packed {
		logic        valid;
		logic        own;
		logic [31:0] accept;
	} cmmc_rxreq_s;

endpackage

// file: tb/cmmc_node_model.sv
// far-side node model: offers received frames to the controller
// assumes the bench calls send from a process that runs off the clock edge
`timescale 1ns/1ps
module cmmc_node_model (
	input  wire logic             CORE_CLK,
	output cmmc_pkg::cmmc_rxreq_s RX_REQ
);
	initial
	begin
		RX_REQ = '0;
	end
	// one frame per call after gap edges; idle shows no stale filter hits
	task automatic send(input logic [31:0] acc, input logic own, input int gap);
		repeat (gap) @(posedge CORE_CLK);
		RX_REQ <= '{valid: 1'b1, own: own, accept: acc};
		@(posedge CORE_CLK);
		RX_REQ <= '{valid: 1'b0, own: ~own, accept: ~acc};
	endtask
endmodule

// file: tb/cmmc_top_asserts.sv
// port-level checks of the mode configuration block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cmmc_top_asserts #(
	parameter int NUM_MB = 32
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RESET,
	input  wire cmmc_pkg::cmmc_rxreq_s RX_REQ,
	input  wire logic                  RX_STORE,
	input  wire logic [4:0]            RX_MB,
	input  wire logic                  RX_ACK,
	input  wire logic [NUM_MB-1:0]     TX_ENABLE,
	input  wire logic [NUM_MB-1:0]     TX_SINGLE,
	input  wire logic                  COMM_RUN,
	input  wire logic                  BUS_TRANSMIT_PIN
);
	default clocking ck @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	a_rx_cause: assert property (RX_STORE |-> $past(RX_REQ.valid && COMM_RUN))
		else $error("store without a taken frame");
	a_rx_hit: assert property (RX_STORE |-> (($past(RX_REQ.accept) >> RX_MB) & 32'h1) != 0)
		else $error("store into a mailbox without a filter hit");
	a_rx_not_tx: assert property (RX_STORE |-> (($past(TX_ENABLE) >> RX_MB) & 1) == 0)
		else $error("store into a transmit mailbox");
	a_ack_own: assert property (RX_ACK |-> $past(RX_REQ.valid && RX_REQ.own))
		else $error("ack without an own frame");
	a_rx_not_single: assert property (RX_STORE |-> (($past(TX_SINGLE) >> RX_MB) & 1) == 0)
		else $error("store into a single-attempt transmit mailbox");
	a_tx_gated: assert property ((TX_ENABLE != '0) |-> COMM_RUN)
		else $error("transmit enabled while communication stopped");
	a_halt_quiet: assert property (!COMM_RUN |=> !RX_STORE && !RX_ACK)
		else $error("store while communication stopped");
	a_reset_out: assert property ($fell(RESET) |-> !RX_STORE && TX_ENABLE == '0 && !COMM_RUN)
		else $error("outputs active after reset");
	a_pin_high: assert property (BUS_TRANSMIT_PIN)
		else $error("transmit pin not high");

	c_store: cover property (RX_STORE);
	c_ack: cover property (RX_ACK);
	c_single: cover property (TX_SINGLE != '0);
endmodule

// file: tb/cmmc_top_tb.sv
// self-checking bench of the mode configuration block
// assumes the package is compiled first and the header is on the include path
`timescale 1ns/1ps
module cmmc_top_tb;
	logic                  CORE_CLK, RESET, CE, WR, RD;
	logic [7:0]            ADDR;
	logic [31:0]           WDATA, RDATA, ABORT_BUSY, TX_ENABLE, TX_SINGLE, d;
	cmmc_pkg::cmmc_rxreq_s RX_REQ;
	logic                  RX_STORE, RX_ACK, COMM_RUN, TQ_TICK, BUS_TRANSMIT_PIN;
	logic [4:0]            RX_MB;
	logic [31:0]           mc [7] = '{32'h0, 32'h0, 32'h40, 32'h60, 32'h80, 32'hA0, 32'h40};
	int                    mismatches, check_count, cycles, n, t;

	cmmc_top #(.NUM_MB(32), .PSC_W(10)) i_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .CE(CE),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_REQ(RX_REQ),
		.ABORT_BUSY(ABORT_BUSY), .RX_STORE(RX_STORE), .RX_MB(RX_MB), .RX_ACK(RX_ACK),
		.TX_ENABLE(TX_ENABLE), .TX_SINGLE(TX_SINGLE), .COMM_RUN(COMM_RUN), .TQ_TICK(TQ_TICK),
		.BUS_TRANSMIT_PIN(BUS_TRANSMIT_PIN));
	cmmc_node_model i_node (.CORE_CLK(CORE_CLK), .RX_REQ(RX_REQ));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CORE_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= v;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge CORE_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	// status must keep the old mode until the switch completes, then show the new one
	task automatic mode(input logic [31:0] ctl, input logic [1:0] old, input logic [2:0] nw);
		wr(8'h00, ctl);
		rd(8'h01, d);
		chk(32'(d[1:0]), 32'(old));
		for (n = 0; n < 30 && d !== 32'(nw); n++)
			rd(8'h01, d);
		chk(d, 32'(nw));
	endtask
	task automatic rx(input logic [31:0] acc, input logic own, input logic st,
		input logic [4:0] mb, input logic ak);
		i_node.send(acc, own, 1);
		#1 chk(32'({RX_ACK, RX_STORE}), 32'({ak, st}));
		if (st)
			chk(32'(RX_MB), 32'(mb));
	endtask
	task automatic ticks(input int exp);
		t = 0;
		repeat (40)
		begin
			@(posedge CORE_CLK);
			#1 t += int'(TQ_TICK);
		end
		chk(32'(t), 32'(exp));
	endtask

	initial
	begin
		CORE_CLK = 1'b0;
		forever #25 CORE_CLK = ~CORE_CLK;
	end
	always @(posedge CORE_CLK)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	initial
	begin
		RESET = 1'b1;
		CE = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = '0;
		WDATA = '0;
		ABORT_BUSY = '0;
		repeat (10) @(posedge CORE_CLK);
		RESET <= 1'b0;
		rd(8'h01, d);
		chk(d, 32'h1);
		rd(8'h10, d);
		chk(d, 32'h0);
		chk(32'(BUS_TRANSMIT_PIN), 32'h1);
		mode(32'h2, 2'h1, 2'h2);
		wr(8'h02, 32'h3);
		wr(8'h03, 32'hA5);
		wr(8'h08, 32'h0F0F);
		CE <= 1'b0;
		wr(8'h02, 32'h7);
		CE <= 1'b1;
		rd(8'h02, d);
		chk(d, 32'h3);
		ticks(10);
		for (int i = 0; i < 7; i++)
		begin
			wr(8'(32'h20 + i), 32'h0);
			wr(8'(32'h20 + i), mc[i]);
		end
		mode(32'h0, 2'h2, 2'h0);
		chk(32'(COMM_RUN), 32'h1);
		chk(TX_ENABLE, 32'h30);
		chk(TX_SINGLE, 32'h20);
		rx(32'h3, 1'b0, 1'b0, 5'h0, 1'b0);
		rx(32'h4C, 1'b0, 1'b1, 5'h2, 1'b0);
		rx(32'h48, 1'b0, 1'b1, 5'h3, 1'b0);
		rx(32'h30, 1'b0, 1'b0, 5'h0, 1'b0);
		rx(32'h44, 1'b1, 1'b0, 5'h0, 1'b0);
		mode(32'h10, 2'h0, 2'h0);
		rx(32'h44, 1'b1, 1'b1, 5'h2, 1'b1);
		mode(32'h2, 2'h0, 2'h2);
		rx(32'h4, 1'b0, 1'b0, 5'h0, 1'b0);
		rd(8'h02, d);
		chk(d, 32'h3);
		rd(8'h03, d);
		chk(d, 32'hA5);
		rd(8'h08, d);
		chk(d, 32'h0F0F);
		rd(8'h23, d);
		chk(d, 32'h60);
		mode(32'h6, 2'h2, 3'h6);
		mode(32'h2, 2'h2, 3'h2);
		mode(32'h8, 2'h2, 2'h0);
		rx(32'h4, 1'b0, 1'b0, 5'h0, 1'b0);
		mode(32'h0, 2'h0, 2'h0);
		rx(32'h4, 1'b0, 1'b1, 5'h2, 1'b0);
		mode(32'h1, 2'h0, 2'h1);
		rd(8'h22, d);
		chk(d, 32'h0);
		chk(TX_ENABLE, 32'h0);
		ticks(0);
		report_and_stop();
	end
endmodule

bind cmmc_top cmmc_top_asserts #(.NUM_MB(NUM_MB)) i_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
	.RX_REQ(RX_REQ), .RX_STORE(RX_STORE), .RX_MB(RX_MB), .RX_ACK(RX_ACK),
	.TX_ENABLE(TX_ENABLE), .TX_SINGLE(TX_SINGLE), .COMM_RUN(COMM_RUN),
	.BUS_TRANSMIT_PIN(BUS_TRANSMIT_PIN));
